// ===== common/pmc_cfg.svh
// Purpose: Offsets, field positions, reset values and timing counts of the power controller
// Assumes: 25 MHz bus clock
// Notes:   Definitions only
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PMC_OFS_CTL 8'h00
`define PMC_OFS_STAT 8'h04

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define PMC_CTL_BKPWE_BIT 8
`define PMC_CTL_LVSEL_HI 7
`define PMC_CTL_LVSEL_LO 5
`define PMC_CTL_LVEN_BIT 4
`define PMC_CTL_STBCLR_BIT 3
`define PMC_CTL_WAKECLR_BIT 2
`define PMC_CTL_STBSEL_BIT 1
`define PMC_CTL_LPSEL_BIT 0
`define PMC_CTL_RESET 32'h0000_0000

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define PMC_STAT_PINEN_BIT 8
`define PMC_STAT_LVFLAG_BIT 2
`define PMC_STAT_STBFLAG_BIT 1
`define PMC_STAT_WAKEFLAG_BIT 0

// ----------------------------------------
// Detector scale, millivolts
// ----------------------------------------
`define PMC_LVD_BASE_MV 2200
`define PMC_LVD_STEP_MV 100
`define PMC_LVD_HYST_MV 100

// ----------------------------------------
// Timing
// ----------------------------------------
`define PMC_CLK_PERIOD_NS 40
`define PMC_RC_WAKE_NS 2000
`define PMC_LDO_WAKE_NS 20000
`define PMC_POR_HOLD_CYC 8

`endif

// ===== common/pmc_pkg.sv
// Purpose: Types of the power controller
// Assumes: Constants live in pmc_cfg.svh
// Notes:   Block state except wpin_prev_reg and the pin synchroniser is one packed struct
`default_nettype none
package pmc_pkg;

  // ----------------------------------------
  // Modes
  // ----------------------------------------
  typedef enum logic [2:0] {
    PMC_RUN,
    PMC_SLEEP,
    PMC_DEEP,
    PMC_DEEP_WAKE,
    PMC_STANDBY,
    PMC_STBY_RST
  } pmc_mode_t;

  // ----------------------------------------
  // Control and state records
  // ----------------------------------------
  typedef struct packed {
    logic backup_write_en;
    logic [2:0] lowvolt_threshold_sel;
    logic lowvolt_detect_en;
    logic standby_select;
    logic regulator_lowpower_sel;
  } pmc_ctl_t;

  typedef struct packed {
    pmc_mode_t mode;
    logic wfe;
    logic lp_used;
    pmc_ctl_t ctl;
    logic wake_pin_en;
    logic standby_flag;
    logic wake_flag;
    logic lowvolt_flag;
    logic [15:0] cnt;
    logic rc_pulse;
    logic [31:0] rdata;
  } pmc_st_t;

endpackage : pmc_pkg
`default_nettype wire

// ===== design/pmc_sync3.sv
// Purpose: Three-stage synchroniser for pin inputs
// Assumes: Inputs asynchronous to MCLK
// Notes:   Output moves only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pmc_sync3 #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
      q <= INIT;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int i = 0; i < W; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          q[i] <= s3_reg[i];
        end
      end
    end
  end
endmodule : pmc_sync3
`default_nettype wire

// ===== design/pmc_lvd_cmp.sv
// Purpose: Supply comparison against the programmed low-voltage threshold
// Assumes: Supply arrives as a millivolt code on MCLK
// Notes:   Hysteresis keeps the flag from chattering
`include "pmc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module pmc_lvd_cmp (
  // Control
  input wire logic en,
  input wire logic [2:0] sel,
  input wire logic flag_now,
  // Supply
  input wire logic [11:0] supply_mv,
  // Result
  output logic flag_next
);
  logic [11:0] thr;
  logic [11:0] thr_hi;

  always_comb begin
    thr = 12'(`PMC_LVD_BASE_MV) + 12'(sel) * 12'(`PMC_LVD_STEP_MV);
    thr_hi = thr + 12'(`PMC_LVD_HYST_MV);
    if (!en) begin
      flag_next = 1'b0;
    end else if (flag_now) begin
      flag_next = (supply_mv <= thr_hi);
    end else begin
      flag_next = (supply_mv <= thr);
    end
  end
endmodule : pmc_lvd_cmp
`default_nettype wire

// ===== design/pmc_top.sv
// Purpose: Power mode controller: sleep, deep-sleep, standby, detector, backup gate
// Assumes: Core wait pulses and controller levels are synchronous to MCLK
// Notes:   RST is the supply-monitor reset; backup domain lives outside
//
// What this block does
// - Regulator stays on from reset release without software help.
// - Supply reset clears all here; backup domain state kept outside.
// - Detector compares only when enabled; flag shows supply versus threshold.
// - Detector output drives external interrupt line sixteen.
// - Wait with deep select clear enters sleep, core clock off only.
// - Sleep wakes on any interrupt or any event, by entry kind.
// - Deep-sleep stops domain clocks and oscillators, keeps contents.
// - Deep-sleep wakes only on external line interrupt or event.
// - Deep-sleep exit selects RC clock, adds regulator delay if low power.
// - Regulator low power in deep-sleep follows its control bit.
// - Deep-sleep refused while any pending or clock-alarm flag set.
// - Standby entry powers off domain, regulator and oscillators.
// - Standby flag set after standby so software sees it.
// - Standby left only on reset pin, clock alarm, watchdog, wake pin.
// - Standby exit issues power-on reset; core restarts at zero.
// - Backup writes ignored until backup write enable set.
// - Bit 3 write one clears standby flag; reads zero.
// - Control register resets to zero, also on standby wake.
// - Bit 2 write one clears wake flag; reads zero.
// - Bit 1 picks standby over deep-sleep; bit 0 low-power regulator.
// - Standby flag cleared only by supply reset or clear bit.
`include "pmc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module pmc_top
  import pmc_pkg::*;
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // Register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  // Core sleep signals
  input wire logic CORE_WAIT,
  input wire logic CORE_WAIT_IS_EVENT,
  input wire logic CORE_DEEPSLEEP_SELECT,
  // Interrupt and event controller
  input wire logic ANY_IRQ,
  input wire logic ANY_EVENT,
  input wire logic EXT_IRQ,
  input wire logic EXT_EVENT,
  input wire logic EXT_IRQ_PENDING,
  input wire logic RTC_FLAGS_SET,
  output logic LOWVOLT_LINE16,
  // Standby wake sources
  input wire logic EXT_RESET_PIN_N,
  input wire logic WAKE_PIN,
  input wire logic RTC_WAKE_EVT,
  input wire logic WATCHDOG_RESET,
  // Supply monitor
  input wire logic [11:0] SUPPLY_MV,
  // Clock and power control
  output logic CORE_CLK_EN,
  output logic DOMAIN_CLK_EN,
  output logic INTERNAL_RC_FAST_OSC_EN,
  output logic FAST_CRYSTAL_OSC_EN,
  output logic PLL_EN,
  output logic RC_SYSCLK_SEL,
  output logic REGULATOR_EN,
  output logic REGULATOR_LOWPOWER,
  output logic DOMAIN_POWER_EN,
  output logic SYS_POR_OUT,
  // Backup domain write gate
  input wire logic BKP_WR_IN,
  output logic BKP_WR_OUT,
  output logic BACKUP_WRITE_EN
);

  // ----------------------------------------
  // Timing counts
  // ----------------------------------------
  localparam int unsigned RC_WAKE_CYC =
    (`PMC_RC_WAKE_NS + `PMC_CLK_PERIOD_NS - 1) / `PMC_CLK_PERIOD_NS;
  localparam int unsigned LDO_WAKE_CYC =
    (`PMC_LDO_WAKE_NS + `PMC_CLK_PERIOD_NS - 1) / `PMC_CLK_PERIOD_NS;
  localparam logic [15:0] POR_HOLD = 16'(`PMC_POR_HOLD_CYC);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [1:0] pins_q;
  logic ext_reset_pin_q;
  logic wpin_q;
  logic wpin_prev_reg;

  pmc_sync3 #(.W(2), .INIT(2'b01)) u_pins (
    .clk(MCLK),
    .rst(RST),
    .d({WAKE_PIN, EXT_RESET_PIN_N}),
    .q(pins_q)
  );
  assign ext_reset_pin_q = pins_q[0];
  assign wpin_q = pins_q[1];

  always_ff @(posedge MCLK) begin
    if (RST) begin
      wpin_prev_reg <= 1'b0;
    end else begin
      wpin_prev_reg <= wpin_q;
    end
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  pmc_st_t s_reg;
  pmc_st_t s_next;
  logic lv_next;
  logic wr_ctl;
  logic wr_stat;
  logic pin_rise;
  logic sleep_wake;
  logic deep_wake;
  logic stby_wake;
  logic deep_blocked;
  logic [15:0] deep_wait;

  pmc_lvd_cmp u_lvd (
    .en(s_reg.ctl.lowvolt_detect_en && s_reg.mode != PMC_STANDBY),
    .sel(s_reg.ctl.lowvolt_threshold_sel),
    .flag_now(s_reg.lowvolt_flag),
    .supply_mv(SUPPLY_MV),
    .flag_next(lv_next)
  );

  always_comb begin
    wr_ctl = REG_WR && REG_ADDR == `PMC_OFS_CTL;
    wr_stat = REG_WR && REG_ADDR == `PMC_OFS_STAT;
    pin_rise = s_reg.wake_pin_en && wpin_q && !wpin_prev_reg;
    sleep_wake = s_reg.wfe ? ANY_EVENT : ANY_IRQ;
    deep_wake = s_reg.wfe ? EXT_EVENT : EXT_IRQ;
    stby_wake = !ext_reset_pin_q || RTC_WAKE_EVT || WATCHDOG_RESET || pin_rise;
    deep_blocked = EXT_IRQ_PENDING || RTC_FLAGS_SET;
    deep_wait = 16'(RC_WAKE_CYC);
    if (s_reg.lp_used) begin
      deep_wait = 16'(RC_WAKE_CYC + LDO_WAKE_CYC);
    end

    s_next = s_reg;
    s_next.rc_pulse = 1'b0;
    s_next.lowvolt_flag = lv_next;

    // Register writes
    if (wr_ctl) begin
      s_next.ctl.backup_write_en = REG_WDATA[`PMC_CTL_BKPWE_BIT];
      s_next.ctl.lowvolt_threshold_sel =
        REG_WDATA[`PMC_CTL_LVSEL_HI:`PMC_CTL_LVSEL_LO];
      s_next.ctl.lowvolt_detect_en = REG_WDATA[`PMC_CTL_LVEN_BIT];
      s_next.ctl.standby_select = REG_WDATA[`PMC_CTL_STBSEL_BIT];
      s_next.ctl.regulator_lowpower_sel = REG_WDATA[`PMC_CTL_LPSEL_BIT];
      if (REG_WDATA[`PMC_CTL_STBCLR_BIT]) begin
        s_next.standby_flag = 1'b0;
      end
      if (REG_WDATA[`PMC_CTL_WAKECLR_BIT]) begin
        s_next.wake_flag = 1'b0;
      end
    end
    if (wr_stat) begin
      s_next.wake_pin_en = REG_WDATA[`PMC_STAT_PINEN_BIT];
    end

    // Wake flag set wins over clear
    if (pin_rise || RTC_WAKE_EVT) begin
      s_next.wake_flag = 1'b1;
    end

    // Mode sequencing
    case (s_reg.mode)
      PMC_RUN: begin
        if (CORE_WAIT) begin
          s_next.wfe = CORE_WAIT_IS_EVENT;
          s_next.lp_used = s_reg.ctl.regulator_lowpower_sel;
          if (!CORE_DEEPSLEEP_SELECT) begin
            s_next.mode = PMC_SLEEP;
          end else if (s_reg.ctl.standby_select) begin
            if (!s_reg.wake_flag) begin
              s_next.mode = PMC_STANDBY;
            end
          end else if (!deep_blocked) begin
            s_next.mode = PMC_DEEP;
          end
        end
      end
      PMC_SLEEP: begin
        if (sleep_wake) begin
          s_next.mode = PMC_RUN;
        end
      end
      PMC_DEEP: begin
        if (deep_wake) begin
          s_next.mode = PMC_DEEP_WAKE;
          s_next.cnt = deep_wait;
          s_next.rc_pulse = 1'b1;
        end
      end
      PMC_DEEP_WAKE: begin
        if (s_reg.cnt <= 16'h0001) begin
          s_next.mode = PMC_RUN;
          s_next.cnt = 16'h0000;
        end else begin
          s_next.cnt = s_reg.cnt - 16'h0001;
        end
      end
      PMC_STANDBY: begin
        s_next.standby_flag = 1'b1;
        if (stby_wake) begin
          s_next.mode = PMC_STBY_RST;
          s_next.cnt = POR_HOLD;
        end
      end
      PMC_STBY_RST: begin
        s_next.ctl = pmc_ctl_t'(`PMC_CTL_RESET);
        s_next.wake_pin_en = 1'b0;
        if (s_reg.cnt <= 16'h0001) begin
          s_next.mode = PMC_RUN;
          s_next.cnt = 16'h0000;
        end else begin
          s_next.cnt = s_reg.cnt - 16'h0001;
        end
      end
      default: begin
        s_next.mode = PMC_RUN;
      end
    endcase

    // Read data, one cycle later
    s_next.rdata = 32'h0000_0000;
    if (REG_RD && REG_ADDR == `PMC_OFS_CTL) begin
      s_next.rdata[`PMC_CTL_BKPWE_BIT] = s_reg.ctl.backup_write_en;
      s_next.rdata[`PMC_CTL_LVSEL_HI:`PMC_CTL_LVSEL_LO] = s_reg.ctl.lowvolt_threshold_sel;
      s_next.rdata[`PMC_CTL_LVEN_BIT] = s_reg.ctl.lowvolt_detect_en;
      s_next.rdata[`PMC_CTL_STBSEL_BIT] = s_reg.ctl.standby_select;
      s_next.rdata[`PMC_CTL_LPSEL_BIT] = s_reg.ctl.regulator_lowpower_sel;
    end else if (REG_RD && REG_ADDR == `PMC_OFS_STAT) begin
      s_next.rdata[`PMC_STAT_PINEN_BIT] = s_reg.wake_pin_en;
      s_next.rdata[`PMC_STAT_LVFLAG_BIT] = s_reg.lowvolt_flag;
      s_next.rdata[`PMC_STAT_STBFLAG_BIT] = s_reg.standby_flag;
      s_next.rdata[`PMC_STAT_WAKEFLAG_BIT] = s_reg.wake_flag;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign REG_RDATA = s_reg.rdata;
  assign LOWVOLT_LINE16 = s_reg.lowvolt_flag;
  assign CORE_CLK_EN = s_reg.mode == PMC_RUN || s_reg.mode == PMC_STBY_RST;
  assign DOMAIN_CLK_EN = s_reg.mode == PMC_RUN || s_reg.mode == PMC_SLEEP
    || s_reg.mode == PMC_STBY_RST;
  assign INTERNAL_RC_FAST_OSC_EN = s_reg.mode != PMC_DEEP
    && s_reg.mode != PMC_STANDBY;
  assign FAST_CRYSTAL_OSC_EN = DOMAIN_CLK_EN;
  assign PLL_EN = DOMAIN_CLK_EN;
  assign RC_SYSCLK_SEL = s_reg.rc_pulse;
  assign REGULATOR_EN = s_reg.mode != PMC_STANDBY;
  assign REGULATOR_LOWPOWER = s_reg.mode == PMC_DEEP && s_reg.lp_used;
  assign DOMAIN_POWER_EN = s_reg.mode != PMC_STANDBY;
  assign SYS_POR_OUT = s_reg.mode == PMC_STBY_RST;
  assign BACKUP_WRITE_EN = s_reg.ctl.backup_write_en;
  assign BKP_WR_OUT = BKP_WR_IN && s_reg.ctl.backup_write_en;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  a_regulator_on_run: assert property (
    s_reg.mode == PMC_RUN |-> REGULATOR_EN && DOMAIN_POWER_EN)
    else $error("regulator off while running");
  a_sleep_clocks: assert property (
    s_reg.mode == PMC_RUN && CORE_WAIT && !CORE_DEEPSLEEP_SELECT
    |=> !CORE_CLK_EN && DOMAIN_CLK_EN)
    else $error("sleep clocks wrong");
  a_deep_osc_off: assert property (
    s_reg.mode == PMC_DEEP |-> !DOMAIN_CLK_EN && !INTERNAL_RC_FAST_OSC_EN
    && !FAST_CRYSTAL_OSC_EN && !PLL_EN)
    else $error("clock or oscillator running in deep-sleep");
  a_deep_refused: assert property (
    s_reg.mode == PMC_RUN && CORE_WAIT && CORE_DEEPSLEEP_SELECT
    && !s_reg.ctl.standby_select && deep_blocked |=> s_reg.mode == PMC_RUN)
    else $error("deep-sleep entered despite pending flag");
  a_deep_exit_delay: assert property (
    s_reg.mode == PMC_DEEP && deep_wake && !s_reg.lp_used
    |=> RC_SYSCLK_SEL ##1 !CORE_CLK_EN [*2])
    else $error("deep-sleep exit sequence wrong");
  a_lowpower_reg: assert property (
    s_reg.mode == PMC_RUN && CORE_WAIT && CORE_DEEPSLEEP_SELECT && !s_reg.ctl.standby_select
    && !deep_blocked |=> REGULATOR_LOWPOWER == $past(s_reg.ctl.regulator_lowpower_sel))
    else $error("regulator mode in deep-sleep wrong");
  a_standby_flag: assert property (
    s_reg.mode == PMC_STANDBY |=> s_reg.standby_flag)
    else $error("standby flag not set");
  a_standby_hold: assert property (
    s_reg.mode == PMC_STANDBY && !stby_wake |=> s_reg.mode == PMC_STANDBY)
    else $error("standby left without wake source");
  a_ctl_wake_clear: assert property (
    s_reg.mode == PMC_STBY_RST ##1 s_reg.mode == PMC_RUN
    |-> s_reg.ctl == pmc_ctl_t'(`PMC_CTL_RESET))
    else $error("control not cleared by standby wake");
  a_backup_gate: assert property (
    wr_ctl && !REG_WDATA[`PMC_CTL_BKPWE_BIT] |=> !BKP_WR_OUT)
    else $error("backup write passed while disabled");
  a_wake_clear: assert property (
    wr_ctl && REG_WDATA[`PMC_CTL_WAKECLR_BIT] && !pin_rise && !RTC_WAKE_EVT
    |=> !s_reg.wake_flag)
    else $error("wake flag not cleared");
  a_lvd_disabled: assert property (
    !s_reg.ctl.lowvolt_detect_en |=> !s_reg.lowvolt_flag)
    else $error("detector flag set while disabled");

  c_sleep_entry: cover property (s_reg.mode == PMC_RUN ##1 s_reg.mode == PMC_SLEEP);
  c_deep_entry: cover property (s_reg.mode == PMC_RUN ##1 s_reg.mode == PMC_DEEP);
  c_standby_wake: cover property (s_reg.mode == PMC_STANDBY ##1 s_reg.mode == PMC_STBY_RST);
  c_deep_refused: cover property (s_reg.mode == PMC_RUN && CORE_WAIT && CORE_DEEPSLEEP_SELECT
    && deep_blocked);

endmodule : pmc_top
`default_nettype wire

// ===== verification/pmc_core_model.sv
// Purpose: Core sleep signals and interrupt/event controller facing the power controller
// Assumes: Bench commands arrive on MCLK
// Notes:   Wake lines rise after a lag, drop when the core clock returns or after 8 cycles
`timescale 1ns/1ps
`default_nettype none
module pmc_core_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bench commands and core clock enable
  input wire logic go_wait,
  input wire logic wfe,
  input wire logic deep,
  input wire logic go_wake,
  input wire logic ext,
  input wire logic [3:0] lag,
  input wire logic core_clk_en,
  // Core and controller side
  output logic core_wait,
  output logic core_wait_is_event,
  output logic core_deepsleep_select,
  output logic any_irq,
  output logic any_event,
  output logic ext_irq,
  output logic ext_event
);
  logic [3:0] lag_reg;
  logic [3:0] hold_reg;
  logic ext_reg;
  logic drive;

  assign drive = (lag_reg == 4'h0) && (hold_reg != 4'h0);
  assign any_irq = drive && !core_wait_is_event;
  assign any_event = drive && core_wait_is_event;
  assign ext_irq = any_irq && ext_reg;
  assign ext_event = any_event && ext_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      core_wait <= 1'b0;
      core_wait_is_event <= 1'b0;
      core_deepsleep_select <= 1'b0;
      lag_reg <= 4'h0;
      hold_reg <= 4'h0;
      ext_reg <= 1'b0;
    end else begin
      core_wait <= go_wait;
      if (go_wait) begin
        core_wait_is_event <= wfe;
      end
      // Select settles before the wait instruction
      if (!go_wait) begin
        core_deepsleep_select <= deep;
      end
      if (go_wake) begin
        lag_reg <= lag;
        hold_reg <= 4'h8;
        ext_reg <= ext;
      end else if (lag_reg != 4'h0) begin
        lag_reg <= lag_reg - 4'h1;
      end else if (hold_reg != 4'h0) begin
        hold_reg <= core_clk_en ? 4'h0 : hold_reg - 4'h1;
      end
    end
  end
endmodule : pmc_core_model
`default_nettype wire

// ===== verification/tb.sv
// Purpose: Self-checking bench of the power mode controller
// Assumes: Partner model drives the core and controller signals
// Notes:   Bench model keeps control and status expectations
`include "pmc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected %s expected %0h seen %0h", nm, (e), (g)); end end
module tb;
  logic MCLK = 1'b0;
  logic RST = 1'b1;
  logic [7:0] REG_ADDR = 8'h00;
  logic [31:0] REG_WDATA = 32'h0;
  logic REG_WR = 1'b0;
  logic REG_RD = 1'b0;
  logic [31:0] REG_RDATA;
  logic CORE_WAIT, CORE_WAIT_IS_EVENT, CORE_DEEPSLEEP_SELECT;
  logic ANY_IRQ, ANY_EVENT, EXT_IRQ, EXT_EVENT, LOWVOLT_LINE16;
  logic EXT_IRQ_PENDING = 1'b0;
  logic RTC_FLAGS_SET = 1'b0;
  logic EXT_RESET_PIN_N = 1'b1;
  logic WAKE_PIN = 1'b0;
  logic RTC_WAKE_EVT = 1'b0;
  logic WATCHDOG_RESET = 1'b0;
  logic [11:0] SUPPLY_MV = 12'hce4;
  logic BKP_WR_IN = 1'b0;
  logic CORE_CLK_EN, DOMAIN_CLK_EN, INTERNAL_RC_FAST_OSC_EN, FAST_CRYSTAL_OSC_EN, PLL_EN;
  logic RC_SYSCLK_SEL, REGULATOR_EN, REGULATOR_LOWPOWER, DOMAIN_POWER_EN, SYS_POR_OUT;
  logic BKP_WR_OUT, BACKUP_WRITE_EN;
  logic go_wait = 1'b0;
  logic wfe = 1'b0;
  logic deep = 1'b0;
  logic go_wake = 1'b0;
  logic ext = 1'b0;
  logic [3:0] lag = 4'h0;
  int err_count = 0;
  int total_checks = 0;
  logic [31:0] lfsr = 32'hc233;
  int m_ctl = 0;
  int m_wpen = 0;
  int m_standby_flag = 0;
  int m_wuf = 0;
  int srcs[$] = '{0, 1, 2, 3};

  always #20 MCLK = ~MCLK;

  pmc_top u_pmc_top (
    .MCLK, .RST, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA,
    .CORE_WAIT, .CORE_WAIT_IS_EVENT, .CORE_DEEPSLEEP_SELECT, .ANY_IRQ, .ANY_EVENT,
    .EXT_IRQ, .EXT_EVENT, .EXT_IRQ_PENDING, .RTC_FLAGS_SET, .LOWVOLT_LINE16,
    .EXT_RESET_PIN_N, .WAKE_PIN, .RTC_WAKE_EVT, .WATCHDOG_RESET, .SUPPLY_MV,
    .CORE_CLK_EN, .DOMAIN_CLK_EN, .INTERNAL_RC_FAST_OSC_EN, .FAST_CRYSTAL_OSC_EN, .PLL_EN,
    .RC_SYSCLK_SEL, .REGULATOR_EN, .REGULATOR_LOWPOWER, .DOMAIN_POWER_EN, .SYS_POR_OUT,
    .BKP_WR_IN, .BKP_WR_OUT, .BACKUP_WRITE_EN
  );

  pmc_core_model u_pmc_core_model (
    .clk(MCLK), .rst(RST), .go_wait, .wfe, .deep, .go_wake, .ext, .lag,
    .core_clk_en(CORE_CLK_EN), .core_wait(CORE_WAIT), .core_wait_is_event(CORE_WAIT_IS_EVENT),
    .core_deepsleep_select(CORE_DEEPSLEEP_SELECT), .any_irq(ANY_IRQ), .any_event(ANY_EVENT),
    .ext_irq(EXT_IRQ), .ext_event(EXT_EVENT)
  );

  // ----------
  // Helpers
  // ----------
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd

  function automatic logic pick(input int w);
    case (w)
      0: return CORE_CLK_EN;
      1: return LOWVOLT_LINE16;
      2: return SYS_POR_OUT;
      default: return RC_SYSCLK_SEL;
    endcase
  endfunction : pick

  task end_sim();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  task automatic wait_for(input int w, input logic v, input int lim, output int n);
    n = 0;
    while (pick(w) !== v && n < lim) begin
      @(negedge MCLK);
      n++;
    end
    if (pick(w) !== v) begin
      err_count++;
      $display("unexpected wait %0d expected %0h seen %0h", w, v, pick(w));
      end_sim();
    end
  endtask : wait_for

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge MCLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge MCLK);
    REG_WR <= 1'b0;
    if (a == `PMC_OFS_CTL) begin
      m_ctl = int'(d & 32'h1f3);
      if (d[3]) m_standby_flag = 0;
      if (d[2]) m_wuf = 0;
    end
    if (a == `PMC_OFS_STAT) m_wpen = int'(d[8]);
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge MCLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge MCLK);
    REG_RD <= 1'b0;
    @(negedge MCLK);
    d = REG_RDATA;
  endtask : reg_rd

  task automatic chk_regs();
    logic [31:0] d;
    reg_rd(`PMC_OFS_CTL, d);
    `CHK("control", m_ctl, d)
    reg_rd(`PMC_OFS_STAT, d);
    `CHK("status", (m_wpen << 8) | (m_standby_flag << 1) | m_wuf, d & 32'hffff_fffb)
  endtask : chk_regs

  task automatic enter(input logic f_wfe, input logic f_deep);
    @(posedge MCLK);
    deep <= f_deep;
    wfe <= f_wfe;
    @(posedge MCLK);
    go_wait <= 1'b1;
    @(posedge MCLK);
    go_wait <= 1'b0;
    @(posedge MCLK);
    @(negedge MCLK);
  endtask : enter

  task automatic wake(input logic f_ext, input logic [3:0] f_lag);
    @(posedge MCLK);
    go_wake <= 1'b1;
    ext <= f_ext;
    lag <= f_lag;
    @(posedge MCLK);
    go_wake <= 1'b0;
    @(negedge MCLK);
  endtask : wake

  // ----------
  // Main sequence
  // ----------
  initial begin
    logic [31:0] d;
    logic [31:0] r;
    int n;
    int thr;
    int ex;
    repeat (4) @(posedge MCLK);
    RST <= 1'b0;
    @(negedge MCLK);
    `CHK("regulator", 1, REGULATOR_EN)
    chk_regs();
    reg_rd(8'h08, d);
    `CHK("unmapped read", 0, d)
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      reg_wr(`PMC_OFS_CTL, r);
      @(posedge MCLK);
      BKP_WR_IN <= r[9];
      @(negedge MCLK);
      `CHK("backup gate", r[9] & r[8], BKP_WR_OUT)
      `CHK("backup enable", r[8], BACKUP_WRITE_EN)
      chk_regs();
    end
    reg_wr(8'h08, 32'hffff_ffff);
    chk_regs();
    reg_wr(`PMC_OFS_CTL, 32'h0);
    @(posedge MCLK);
    SUPPLY_MV <= 12'd2000;
    repeat (4) @(negedge MCLK);
    `CHK("detector off", 0, LOWVOLT_LINE16)
    for (int s = 0; s < 8; s++) begin
      thr = `PMC_LVD_BASE_MV + `PMC_LVD_STEP_MV * s;
      @(posedge MCLK);
      SUPPLY_MV <= 12'(thr + 1 + rnd() % 50);
      reg_wr(`PMC_OFS_CTL, (s << 5) | 32'h10);
      repeat (4) @(negedge MCLK);
      `CHK("above threshold", 0, LOWVOLT_LINE16)
      @(posedge MCLK);
      SUPPLY_MV <= 12'(thr);
      wait_for(1, 1'b1, 8, n);
      reg_rd(`PMC_OFS_STAT, d);
      `CHK("low flag", 1, d[2])
      @(posedge MCLK);
      SUPPLY_MV <= 12'd3300;
      wait_for(1, 1'b0, 8, n);
    end
    for (int k = 0; k < 2; k++) begin
      enter(k[0], 1'b0);
      `CHK("sleep clocks", 2'b01, ({CORE_CLK_EN, DOMAIN_CLK_EN}))
      wake(1'b0, 4'(k * 5));
      wait_for(0, 1'b1, 12, n);
      `CHK("sleep wake time", k * 5 + 1, n)
    end
    reg_wr(`PMC_OFS_CTL, 32'h0);
    @(posedge MCLK);
    EXT_IRQ_PENDING <= 1'b1;
    enter(1'b0, 1'b1);
    `CHK("refused pending", 1, CORE_CLK_EN)
    @(posedge MCLK);
    EXT_IRQ_PENDING <= 1'b0;
    RTC_FLAGS_SET <= 1'b1;
    enter(1'b1, 1'b1);
    `CHK("refused alarm", 1, CORE_CLK_EN)
    @(posedge MCLK);
    RTC_FLAGS_SET <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      reg_wr(`PMC_OFS_CTL, 32'h100 | k);
      enter(k[0], 1'b1);
      `CHK("deep clocks", 0, ({CORE_CLK_EN, DOMAIN_CLK_EN}))
      `CHK("deep osc", 0, ({INTERNAL_RC_FAST_OSC_EN, FAST_CRYSTAL_OSC_EN, PLL_EN}))
      `CHK("deep regulator", ({1'b1, k[0]}), ({REGULATOR_EN, REGULATOR_LOWPOWER}))
      wake(1'b0, 4'h0);
      repeat (10) @(negedge MCLK);
      `CHK("deep foreign wake", 0, CORE_CLK_EN)
      wake(1'b1, 4'h3);
      wait_for(3, 1'b1, 12, n);
      `CHK("rc oscillator", 1, INTERNAL_RC_FAST_OSC_EN)
      wait_for(0, 1'b1, 600, n);
      ex = (`PMC_RC_WAKE_NS + k * `PMC_LDO_WAKE_NS) / `PMC_CLK_PERIOD_NS;
      `CHK("deep wake time", 1, (n >= ex - 1 && n <= ex + 2))
      chk_regs();
    end
    foreach (srcs[j]) begin
      reg_wr(`PMC_OFS_STAT, 32'h100);
      reg_wr(`PMC_OFS_CTL, 32'h106 | (rnd() & 32'he0));
      enter(1'b0, 1'b1);
      `CHK("standby power", 0, ({REGULATOR_EN, DOMAIN_POWER_EN}))
      `CHK("standby osc", 0, ({INTERNAL_RC_FAST_OSC_EN, FAST_CRYSTAL_OSC_EN, PLL_EN}))
      wake(1'b1, 4'h0);
      repeat (10) @(negedge MCLK);
      `CHK("standby foreign wake", 0, DOMAIN_POWER_EN)
      @(posedge MCLK);
      case (srcs[j])
        0: EXT_RESET_PIN_N <= 1'b0;
        1: RTC_WAKE_EVT <= 1'b1;
        2: WATCHDOG_RESET <= 1'b1;
        default: WAKE_PIN <= 1'b1;
      endcase
      @(posedge MCLK);
      RTC_WAKE_EVT <= 1'b0;
      WATCHDOG_RESET <= 1'b0;
      wait_for(2, 1'b1, 12, n);
      wait_for(2, 1'b0, 20, n);
      `CHK("reset length", `PMC_POR_HOLD_CYC, n)
      @(posedge MCLK);
      EXT_RESET_PIN_N <= 1'b1;
      WAKE_PIN <= 1'b0;
      m_ctl = 0;
      m_wpen = 0;
      m_standby_flag = 1;
      if (srcs[j] % 2 == 1) m_wuf = 1;
      chk_regs();
    end
    reg_wr(`PMC_OFS_CTL, 32'h2);
    enter(1'b0, 1'b1);
    `CHK("standby refused", 1, DOMAIN_POWER_EN)
    reg_wr(`PMC_OFS_CTL, 32'h0);
    chk_regs();
    reg_wr(`PMC_OFS_CTL, 32'hc);
    chk_regs();
    end_sim();
  end
endmodule : tb
`default_nettype wire
